/* File: src/usbevc_regs.sv */
// Purpose: USB device event flags, address and configuration registers
// Assumes: Classic Wishbone slave, one clock, synchronous reset
// Notes:   Ack one cycle after request, dropped the next cycle
`timescale 1ns/1ns
`default_nettype none
`include "usbevc_params.svh"
module usbevc_regs (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // Events from the serial engine, one-cycle pulses
  input  wire logic                  bus_reset_evt_i,
  input  wire logic                  bus_suspend_evt_i,
  input  wire logic                  resume_evt_i,
  input  wire logic                  sof_evt_i,
  input  wire logic                  wakeup_evt_i,
  input  wire logic [7:0]            ep0_evt_i,
  input  wire logic [3:0]            ep_ack_evt_i,
  input  wire logic [3:0]            ep_nak_evt_i,
  // Power state pins, asynchronous
  input  wire logic                  sleep_i,
  input  wire logic                  deep_sleep_i,
  // Controls
  output logic      [6:0]            device_addr_field_o,
  output usbevc_pkg::usbevc_cfg_t    cfg_o,
  output logic                       core_supply_sel_o,
  // Interrupt
  output logic                       irq_o
);

  usbevc_pkg::usbevc_wb_req_t    req;
  usbevc_pkg::usbevc_bus_state_t bus_state_reg;
  logic [31:0] event_status;
  logic [31:0] event_set;
  logic [31:0] clear_pulse;
  logic [31:0] irq_enable_reg;
  logic [31:0] irq_mask_reg;
  logic [6:0]  device_addr_reg;
  logic [31:0] bus_cfg_reg;
  logic [31:0] dat_reg;
  logic [1:0]  sleep_sync_reg;
  logic [1:0]  deep_sync_reg;
  logic        take;
  logic        wr;
  logic [31:0] irq_gate;
  logic [31:0] addr_merged;

  // Byte-lane write merge
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : wb_merge

  assign req  = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};
  assign take = req.cyc && req.stb && (bus_state_reg == usbevc_pkg::USBEVC_IDLE);
  assign wr   = take && req.we;

  // Answer one cycle later, drop the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_reg <= usbevc_pkg::USBEVC_IDLE;
    end else begin
      case (bus_state_reg)
        usbevc_pkg::USBEVC_IDLE: begin
          if (take) begin
            bus_state_reg <= usbevc_pkg::USBEVC_ACK;
          end
        end
        usbevc_pkg::USBEVC_ACK: begin
          bus_state_reg <= usbevc_pkg::USBEVC_IDLE;
        end
        default: begin
          bus_state_reg <= usbevc_pkg::USBEVC_IDLE;
        end
      endcase
    end
  end

  assign ack_o = (bus_state_reg == usbevc_pkg::USBEVC_ACK);

  // Sleep pins cross in from outside
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_sync_reg <= 2'h0;
      deep_sync_reg  <= 2'h0;
    end else begin
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_i};
      deep_sync_reg  <= {deep_sync_reg[0], deep_sleep_i};
    end
  end

  always_comb begin
    event_set = 32'h00000000;
    event_set[`USBEVC_BIT_BUS_RESET]   = bus_reset_evt_i;
    event_set[`USBEVC_BIT_BUS_SUSPEND] = bus_suspend_evt_i;
    event_set[`USBEVC_BIT_RESUME]      = resume_evt_i;
    event_set[`USBEVC_BIT_SOF]         = sof_evt_i;
    event_set[`USBEVC_BIT_WAKEUP]      = wakeup_evt_i;
    event_set[`USBEVC_BIT_SETUP_TOKEN -: 8] = ep0_evt_i;
    event_set[`USBEVC_BIT_ACK_LO +: 4] = ep_ack_evt_i;
    event_set[`USBEVC_BIT_NAK_LO +: 4] = ep_nak_evt_i;
    event_set = event_set & `USBEVC_SETTABLE;
  end

  always_comb begin
    clear_pulse = 32'h00000000;
    if (wr && (req.adr == `USBEVC_OFF_EVENT_CLEAR)) begin
      clear_pulse = wb_merge(32'h00000000, req.dat, req.sel) & `USBEVC_CLEARABLE;
    end
  end

  usbevc_flags u_flags (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (event_set),
    .clear_i (clear_pulse),
    .flags_o (event_status)
  );

  // Interrupt enable and mask registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable_reg <= 32'h00000000;
      irq_mask_reg   <= 32'h00000000;
    end else if (wr && (req.adr == `USBEVC_OFF_IRQ_ENABLE)) begin
      irq_enable_reg <= wb_merge(irq_enable_reg, req.dat, req.sel) & `USBEVC_IRQ_EN_MASK;
    end else if (wr && (req.adr == `USBEVC_OFF_IRQ_MASK)) begin
      irq_mask_reg <= wb_merge(irq_mask_reg, req.dat, req.sel);
    end
  end

  // Merged word as a net, so only its low bits are kept
  assign addr_merged = wb_merge({25'h0000000, device_addr_reg}, req.dat, req.sel);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      device_addr_reg <= 7'h00;
    end else if (wr && (req.adr == `USBEVC_OFF_DEV_ADDR)) begin
      device_addr_reg <= addr_merged[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_cfg_reg <= `USBEVC_CFG_RESET;
    end else if (wr && (req.adr == `USBEVC_OFF_BUS_CFG)) begin
      bus_cfg_reg <= wb_merge(bus_cfg_reg, req.dat, req.sel) & `USBEVC_CFG_MASK;
    end
  end

  always_comb begin
    irq_gate = event_status & ~`USBEVC_NO_IRQ;
    irq_gate[`USBEVC_BIT_NAK_LO +: 4] = event_status[`USBEVC_BIT_NAK_LO +: 4]
                                        & irq_enable_reg[3:0];
    irq_gate[`USBEVC_BIT_ACK_LO +: 4] = event_status[`USBEVC_BIT_ACK_LO +: 4]
                                        & {4{irq_enable_reg[`USBEVC_BIT_ACK_IRQ_EN]}};
  end

  // Mask bit one blocks its source
  assign irq_o = |(irq_gate & ~irq_mask_reg);

  // Read data, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h00000000;
    end else if (take && !req.we) begin
      case (req.adr)
        `USBEVC_OFF_IRQ_ENABLE:   dat_reg <= irq_enable_reg;
        `USBEVC_OFF_EVENT_STATUS: dat_reg <= event_status;
        `USBEVC_OFF_DEV_ADDR:     dat_reg <= {25'h0000000, device_addr_reg};
        `USBEVC_OFF_BUS_CFG:      dat_reg <= bus_cfg_reg;
        `USBEVC_OFF_IRQ_MASK:     dat_reg <= irq_mask_reg;
        default:                  dat_reg <= 32'h00000000;
      endcase
    end
  end

  assign dat_o               = dat_reg;
  assign device_addr_field_o = device_addr_reg;

  assign cfg_o.regulator_out_enable = bus_cfg_reg[`USBEVC_BIT_CFG_REGULATOR];
  assign core_supply_sel_o          = ~bus_cfg_reg[`USBEVC_BIT_CFG_REGULATOR];
  assign cfg_o.transceiver_enable   = bus_cfg_reg[`USBEVC_BIT_CFG_XCVR]
                                      & ~sleep_sync_reg[1] & ~deep_sync_reg[1];
  assign cfg_o.dplus_pullup_enable  = bus_cfg_reg[`USBEVC_BIT_CFG_PULLUP];
  assign cfg_o.serial_engine_enable = bus_cfg_reg[`USBEVC_BIT_CFG_ENGINE];
  assign cfg_o.esd_protect_enable   = bus_cfg_reg[`USBEVC_BIT_CFG_ESD];
  assign cfg_o.line_pulldown_enable = bus_cfg_reg[`USBEVC_BIT_CFG_PULLDOWN];
  assign cfg_o.endpoint_direction   = bus_cfg_reg[`USBEVC_BIT_CFG_DIR_LO +: 4];

endmodule : usbevc_regs
`default_nettype wire

/* File: common/usbevc_params.svh */
// Purpose: Offsets, field positions, reset values for the USB event/config bank
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes:   Included by bare name
`ifndef USBEVC_PARAMS_SVH
`define USBEVC_PARAMS_SVH

`define USBEVC_OFF_IRQ_ENABLE   8'h00
`define USBEVC_OFF_EVENT_STATUS 8'h04
`define USBEVC_OFF_EVENT_CLEAR  8'h08
`define USBEVC_OFF_DEV_ADDR     8'h0c
`define USBEVC_OFF_BUS_CFG      8'h10
`define USBEVC_OFF_IRQ_MASK     8'h2c

`define USBEVC_BIT_BUS_RESET    31
`define USBEVC_BIT_BUS_SUSPEND  30
`define USBEVC_BIT_RESUME       29
`define USBEVC_BIT_SOF          26
`define USBEVC_BIT_WAKEUP       25
`define USBEVC_BIT_SETUP_TOKEN  24
`define USBEVC_BIT_ERR_SETUP    18
`define USBEVC_BIT_ERR_TIMEOUT  17
`define USBEVC_BIT_ACK_LO       8
`define USBEVC_BIT_NAK_LO       0
`define USBEVC_BIT_ACK_IRQ_EN   4

// Configuration field positions
`define USBEVC_BIT_CFG_REGULATOR 31
`define USBEVC_BIT_CFG_XCVR      30
`define USBEVC_BIT_CFG_PULLUP    29
`define USBEVC_BIT_CFG_ENGINE    28
`define USBEVC_BIT_CFG_ESD       27
`define USBEVC_BIT_CFG_PULLDOWN  26
`define USBEVC_BIT_CFG_DIR_LO    0

// Flags that software may clear: 31,29,26,25,24..17,11..8,3..0
`define USBEVC_CLEARABLE        32'ha7fe0f0f
// Flags that may be set at all (adds suspend, level-free bit 30)
`define USBEVC_SETTABLE         32'he7fe0f0f
// Events that never raise the interrupt: setup token, bad setup, timeout
`define USBEVC_NO_IRQ           32'h01060000
`define USBEVC_IRQ_EN_MASK      32'h0000001f
`define USBEVC_ADDR_MASK        32'h0000007f
`define USBEVC_CFG_MASK         32'hfc00000f
`define USBEVC_CFG_RESET        32'h80000000

`endif

/* File: common/usbevc_pkg.sv */
// Purpose: Types for the USB event/config bank
// Assumes: Used with usbevc_params.svh
// Notes:   Nothing is imported; use usbevc_pkg::name
package usbevc_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } usbevc_wb_req_t;

  typedef struct packed {
    logic        regulator_out_enable;
    logic        transceiver_enable;
    logic        dplus_pullup_enable;
    logic        serial_engine_enable;
    logic        esd_protect_enable;
    logic        line_pulldown_enable;
    logic [3:0]  endpoint_direction;
  } usbevc_cfg_t;

  typedef enum logic [0:0] {
    USBEVC_IDLE = 1'b0,
    USBEVC_ACK  = 1'b1
  } usbevc_bus_state_t;

endpackage : usbevc_pkg

/* File: src/usbevc_flags.sv */
// Purpose: Sticky event flags with write-one-to-clear
// Assumes: Events are single-cycle pulses on clk_i
// Notes:   A set in the clear cycle wins
`timescale 1ns/1ns
`default_nettype none
module usbevc_flags (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Events and clears
  input  wire logic [31:0] set_i,
  input  wire logic [31:0] clear_i,
  // Flags
  output logic      [31:0] flags_o
);
  logic [31:0] flags_reg;
  logic [31:0] flags_next;

  always_comb begin
    flags_next = (flags_reg & ~clear_i) | set_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= 32'h00000000;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags_o = flags_reg;
endmodule : usbevc_flags
`default_nettype wire

/* File: verif/usbevc_assertions.sv */
// Purpose: Port assertions for usbevc_regs
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the design at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module usbevc_checker (
  // Clock, reset and bus
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    cyc_i,
  input wire logic                    stb_i,
  input wire logic                    we_i,
  input wire logic [3:0]              sel_i,
  input wire logic [7:0]              adr_i,
  input wire logic [31:0]             dat_i,
  input wire logic [31:0]             dat_o,
  input wire logic                    ack_o,
  // Power and controls
  input wire logic                    sleep_i,
  input wire logic                    deep_sleep_i,
  input wire logic [6:0]              device_addr_field_o,
  input wire usbevc_pkg::usbevc_cfg_t cfg_o,
  input wire logic                    core_supply_sel_o,
  input wire logic                    irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_once: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  chk_reset_vals: assert property ($fell(rst_i) |->
    cfg_o == 10'h200 && device_addr_field_o == 7'h0 && !irq_o && !ack_o)
    else $error("bad values after reset");
  chk_addr_upper: assert property (ack_o && $past(!we_i && adr_i == 8'h0c)
    |-> dat_o[31:7] == 25'h0) else $error("address upper bits set");
  chk_addr_write: assert property (ack_o && $past(we_i && adr_i == 8'h0c && sel_i[0])
    |-> device_addr_field_o == $past(dat_i[6:0])) else $error("address not written");
  chk_status_rsvd: assert property (ack_o && $past(!we_i && adr_i == 8'h04)
    |-> {dat_o[28:27], dat_o[16:12], dat_o[7:4]} == 11'h0) else $error("reserved set");
  chk_clear_reads: assert property (ack_o && $past(!we_i && adr_i == 8'h08)
    |-> dat_o == 32'h0) else $error("clear register readable");
  chk_cfg_write: assert property (ack_o && $past(we_i && adr_i == 8'h10 && sel_i == 4'hf)
    |-> {cfg_o.regulator_out_enable, cfg_o[7:0]} == $past({dat_i[31], dat_i[29:26], dat_i[3:0]}))
    else $error("config not written");
  chk_core_supply: assert property (core_supply_sel_o == !cfg_o.regulator_out_enable)
    else $error("supply select wrong");
  chk_phy_sleep: assert property ((sleep_i || deep_sleep_i) [*3] |=>
    !cfg_o.transceiver_enable) else $error("transceiver on in sleep");
endmodule : usbevc_checker
bind usbevc_regs usbevc_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i,
  .dat_i, .dat_o, .ack_o, .sleep_i, .deep_sleep_i, .device_addr_field_o, .cfg_o,
  .core_supply_sel_o, .irq_o);
`default_nettype wire

/* File: verif/usbevc_host_model.sv */
// Purpose: Far-side event source for the event bank
// Assumes: One clock; events are one-cycle pulses
// Notes:   Bit layout follows the status register
`timescale 1ns/1ns
`default_nettype none
module usbevc_host_model (
  // Clock
  input  wire logic        clk_i,
  // Event pulses
  output var  logic [31:0] evt_o
);
  initial evt_o = 32'h0;
  // One cycle only, so each event sets its flag once
  task automatic fire(input logic [31:0] v);
    @(posedge clk_i);
    evt_o <= v;
    @(posedge clk_i);
    evt_o <= 32'h0;
  endtask : fire
endmodule : usbevc_host_model
`default_nettype wire

/* File: verif/usbevc_tb_top.sv */
// Purpose: Self-checking bench for usbevc_regs
// Assumes: Mask bit one blocks its interrupt
// Notes:   Wishbone master waits for ack, bounded
`timescale 1ns/1ns
`default_nettype none
module usbevc_tb_top;
  logic clk, rst, ack, slp, dslp, csup, irq;
  logic [31:0] rd, evt;
  logic [6:0] addr;
  usbevc_pkg::usbevc_wb_req_t req;
  usbevc_pkg::usbevc_cfg_t cfg;
  int err_count = 0;
  int checks = 0;
  usbevc_host_model host_u (.clk_i(clk), .evt_o(evt));
  usbevc_regs dut_u (.clk_i(clk), .rst_i(rst), .cyc_i(req.cyc), .stb_i(req.stb),
    .we_i(req.we), .sel_i(req.sel), .adr_i(req.adr), .dat_i(req.dat), .dat_o(rd),
    .ack_o(ack), .bus_reset_evt_i(evt[31]), .bus_suspend_evt_i(evt[30]),
    .resume_evt_i(evt[29]), .sof_evt_i(evt[26]), .wakeup_evt_i(evt[25]),
    .ep0_evt_i(evt[24:17]), .ep_ack_evt_i(evt[11:8]), .ep_nak_evt_i(evt[3:0]),
    .sleep_i(slp), .deep_sleep_i(dslp), .device_addr_field_o(addr), .cfg_o(cfg),
    .core_supply_sel_o(csup), .irq_o(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Holds the request until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rd;
    req <= '0;
    if (n >= 50) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, ack, 1'b1);
    end
  endtask : wb
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : w
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rc
  task automatic ci(input logic e);
    @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : ci
  task automatic t_ep();
    host_u.fire(32'h00000f0f);
    rc(8'h04, 32'h00000f0f);
    w(8'h08, 32'h5801f0f0);
    w(8'h04, 32'h0);
    rc(8'h04, 32'h00000f0f);
    w(8'h08, 32'h00000108);
    rc(8'h04, 32'h00000e07);
    w(8'h08, 32'h00000e07);
    rc(8'h04, 32'h0);
  endtask : t_ep
  task automatic t_race();
    fork
      w(8'h08, 32'h1);
      host_u.fire(32'h1);
    join
    rc(8'h04, 32'h1);
    w(8'h08, 32'h1);
  endtask : t_race
  task automatic t_irq();
    host_u.fire(32'h1);
    ci(1'b0);
    w(8'h00, 32'h1);
    ci(1'b1);
    w(8'h2c, 32'h1);
    ci(1'b0);
    w(8'h2c, 32'h0);
    w(8'h08, 32'h1);
    host_u.fire(32'h200);
    ci(1'b0);
    w(8'h00, 32'h10);
    ci(1'b1);
    w(8'h08, 32'h200);
    ci(1'b0);
  endtask : t_irq
  task automatic t_cfg();
    w(8'h10, 32'hffffffff);
    rc(8'h10, 32'hfc00000f);
    @(posedge clk) slp <= 1'b1;
    repeat (5) @(posedge clk);
    chk({22'h0, cfg}, 32'h2ff);
    slp <= 1'b0;
    dslp <= 1'b1;
    repeat (5) @(posedge clk);
    chk({22'h0, cfg}, 32'h2ff);
    dslp <= 1'b0;
    repeat (5) @(posedge clk);
    chk({22'h0, cfg}, 32'h3ff);
    w(8'h10, 32'h22000005);
    chk({21'h0, cfg, csup}, 32'h10b);
    w(8'h0c, 32'hffffffff);
    rc(8'h0c, 32'h7f);
    chk({25'h0, addr}, 32'h7f);
    rc(8'h40, 32'h0);
  endtask : t_cfg
  task automatic t_misc();
    host_u.fire(32'he7fe0000);
    rc(8'h04, 32'he7fe0000);
    w(8'h08, 32'hffffffff);
    rc(8'h04, 32'h40000000);
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(8'h04, 32'h0);
    rc(8'h0c, 32'h0);
    rc(8'h10, 32'h80000000);
  endtask : t_misc
  task automatic give_verdict();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    slp = 1'b0;
    dslp = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(8'h10, 32'h80000000);
    chk({20'h0, cfg, csup, irq}, 32'h800);
    t_ep();
    t_race();
    t_irq();
    t_cfg();
    t_misc();
    give_verdict();
  end
endmodule : usbevc_tb_top
`default_nettype wire
